// *** rtl/shared_regs_params.svh ***
// offsets, field positions, reset values and the power move cycle count of the shared register bank
`ifndef SHARED_REGS_PARAMS_SVH
`define SHARED_REGS_PARAMS_SVH
`define ADR_TOP_STAT 8'h00
`define ADR_DEV_STAT 8'h01
`define ADR_HOST_STAT 8'h02
`define ADR_CPU_STAT 8'h03
`define ADR_BUF_STAT 8'h04
`define ADR_TOP_EN 8'h08
`define ADR_DEV_EN 8'h09
`define ADR_HOST_EN 8'h0A
`define ADR_CPU_EN 8'h0B
`define ADR_BUF_EN 8'h0C
`define ADR_REVISION 8'h10
`define ADR_CHIP_RESET 8'h11
`define ADR_PM_CTRL 8'h12
`define ADR_WAKE_HI 8'h14
`define ADR_WAKE_LO 8'h15
`define ADR_HOST_PWR 8'h16
`define ADR_HOST_XCVR 8'h17
`define ADR_DEV_LINE 8'h18
`define ADR_HOST_LINE 8'h19
`define ADR_XCVR_TUNE 8'h1B
`define ADR_ROLE_SEL 8'h1F
`define ADR_DMA_CTRL 8'h40
`define ADR_DMA_CFG 8'h41
`define ADR_DMA_CNT_HI 8'h42
`define ADR_DMA_CNT_LO 8'h43
`define RST_CHIP_RESET 8'h80
`define RST_HOST_XCVR 8'h91
`define RST_ZERO 8'h00
`define REVISION_VALUE 8'h5A
`define BIT_TOP_DEV 7
`define BIT_TOP_HOST 6
`define BIT_TOP_CPU 5
`define BIT_TOP_BUF 4
`define BIT_TOP_PM 0
`define BIT_CPU_DMA_DONE 0
`define BIT_CPU_DMA_WRAP 1
`define BIT_CPU_RAM_RD 7
`define BIT_BUF_EMPTY 0
`define BIT_BUF_FULL 1
`define BIT_BUF_NEMPTY 2
`define BIT_BUF_DMA_DONE 7
`define BIT_PM_SLEEP 7
`define BIT_PM_ACTIVE 6
`define BIT_PM_CUT 5
`define BIT_XCVR_RESET 7
`define BIT_FULL_RESET 0
`define BIT_DMA_GO 0
`define BIT_DMA_STOP 1
`define BIT_DMA_RUN 7
`define BIT_CFG_COUNT 0
`define BIT_CFG_FREE 1
`define PM_CYCLES 8
`endif

// *** rtl/shared_regs_pkg.sv ***
// types shared by the register bank, its assertions and its bench
package shared_regs_pkg;
  typedef enum logic [1:0] {
    PM_SLEEP = 2'b00,
    PM_ACTIVE = 2'b01,
    PM_CUT = 2'b10,
    PM_MOVING = 2'b11
  } power_state_t;
  typedef enum logic [1:0] {
    REQ_IDLE = 2'b00,
    REQ_ON = 2'b01,
    REQ_GAP = 2'b10
  } req_state_t;
endpackage : shared_regs_pkg

// *** rtl/burst_tracker.sv ***
// counts bytes of one dma request burst and flags its end
`timescale 1ns/1ns
module burst_tracker #(
  parameter int W = 5
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, low
  input wire logic load, // start of a burst
  input wire logic [W-1:0] length, // bytes guaranteed in burst
  input wire logic step, // one byte moved
  output logic done // burst used up, level
);
  typedef struct packed {
    logic [W-1:0] left;
  } st_t;
  st_t s_q;
  st_t s_d;
  // load wins over step so a new burst never inherits a stale count
  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.left = length;
    end else if (step && s_q.left != '0) begin
      s_d.left = s_q.left - W'(1);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign done = (s_q.left == '0);
endmodule : burst_tracker

// *** rtl/shared_regs_dma_burst_req.sv ***
// shared control/status register bank with burst-count dma read request
// Operation
// - request when buffer data exceeds burst count
// - asserted request guarantees full burst length
// - count mode: remaining count sets guarantee
// - request drops briefly after every burst
// - running flag stays one until stopped or count ends
// - dma path offers a single-byte read only as a count-mode remainder
// - shared registers stay accessible while sleeping
// - top status summarises four groups, pm done
// - enables eight above status, gate propagation
// - cpu status: dma done, wrap, ram
// - buffer status: empty, full, not-empty, dma
// - power commands and two-bit state field
// - chip reset resets to transceiver reset set
// - role select bit zero, resets zero
// - free-run counter wrap sets overflow status
`timescale 1ns/1ns
`include "shared_regs_params.svh"
module shared_regs_dma_burst_req #(
  parameter int CNT_W = 16, // width of transfer byte counter
  parameter int FILL_W = 13 // width of buffer fill level
) (
  input wire logic clk, // system clock, 25 MHz
  input wire logic rst_n, // async reset, low
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  output logic irq, // level interrupt, high
  input wire logic [7:0] dev_events, // device engine event pulses
  input wire logic [7:0] host_events, // host engine event pulses
  input wire logic ram_read_complete, // ram read done pulse
  input wire logic buffer_empty, // buffer empty level
  input wire logic buffer_full, // buffer full level
  input wire logic [FILL_W-1:0] buffer_fill, // readable bytes
  input wire logic buffer_readable, // buffer open to external reads
  input wire logic [7:0] dev_line_in, // device line status level
  input wire logic [7:0] host_line_in, // host line status level
  input wire logic dma_ack_n, // dma acknowledge pin, low
  input wire logic dma_strobe, // one byte moved, pulse
  output logic dma_request_n, // dma request pin, low
  output logic transceiver_reset, // transceiver held in reset
  output logic full_logic_reset, // full logic reset command
  output logic role_host_select, // 1 host, 0 device
  output shared_regs_pkg::power_state_t power_state // power state
);
  import shared_regs_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] dev_st;
    logic [7:0] host_st;
    logic [7:0] cpu_st;
    logic [7:0] buf_st;
    logic pm_done;
    logic [7:0] top_en;
    logic [7:0] dev_en;
    logic [7:0] host_en;
    logic [7:0] cpu_en;
    logic [7:0] buf_en;
    logic [7:0] chip_rst;
    logic [2:0] pm_cmd;
    power_state_t pm;
    logic [3:0] pm_timer;
    logic [15:0] wake;
    logic [7:0] host_pwr;
    logic [7:0] xcvr;
    logic [7:0] tune;
    logic role;
    logic [1:0] burst_cfg;
    logic count_mode;
    logic free_run;
    logic running;
    logic [CNT_W-1:0] count;
    req_state_t req;
    logic [1:0] ack_s;
    logic prev_empty;
    logic prev_full;
    logic [7:0] rdata;
  } st_t;
  st_t s_q;
  st_t s_d;

  logic burst_done;
  logic burst_load;
  logic [4:0] burst_len;
  logic [4:0] burst_bytes;
  logic have_burst;
  logic have_rest;
  logic byte_move;
  logic ack_sync;
  logic [7:0] top_val;

  // burst field counts 16-bit beats: 0..3 means 2,4,8,16 bytes
  assign burst_bytes = 5'(5'h02 << s_q.burst_cfg);
  // exceed test; a single-byte read is offered only as a count-mode remainder of one
  assign have_burst = buffer_fill > FILL_W'(burst_bytes);
  assign have_rest = s_q.count_mode && s_q.count != '0 &&
    CNT_W'(buffer_fill) > s_q.count;
  assign ack_sync = s_q.ack_s[1];
  assign byte_move = dma_strobe && !ack_sync && s_q.running;
  // guaranteed length: full burst, else the remaining count
  // count fits 5 bits: that path only wins when count < fill <= 16
  assign burst_len = have_burst ? burst_bytes : 5'(s_q.count);
  assign burst_load = s_q.req == REQ_IDLE && s_q.running &&
    buffer_readable && (have_burst || have_rest);

  burst_tracker #(
    .W(5)
  ) u_burst (
    .clk(clk),
    .rst_n(rst_n),
    .load(burst_load),
    .length(burst_len),
    .step(byte_move),
    .done(burst_done)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic wsel;
    logic cnt_wrap;
    logic cnt_end;
    logic empty_rise;
    logic full_rise;
    wsel = 1'b0;
    cnt_wrap = 1'b0;
    cnt_end = 1'b0;
    empty_rise = buffer_empty && !s_q.prev_empty;
    full_rise = buffer_full && !s_q.prev_full;
    s_d = s_q;
    // two flops on the acknowledge pin; only the second is ever read
    s_d.ack_s = {s_q.ack_s[0], dma_ack_n};
    s_d.prev_empty = buffer_empty;
    s_d.prev_full = buffer_full;
    s_d.rdata = 8'h00;

    // byte counter: count mode runs down, free-run counts up and wraps
    if (byte_move) begin
      if (s_q.free_run) begin
        s_d.count = s_q.count + CNT_W'(1);
        cnt_wrap = (s_q.count == '1);
      end else if (s_q.count_mode && s_q.count != '0) begin
        s_d.count = s_q.count - CNT_W'(1);
        cnt_end = (s_q.count == CNT_W'(1));
      end
    end

    // request sequencing with a forced gap after each burst
    unique case (s_q.req)
      REQ_IDLE: begin
        if (burst_load) begin
          s_d.req = REQ_ON;
        end
      end
      REQ_ON: begin
        if (!s_q.running || cnt_end) begin
          s_d.req = REQ_IDLE;
        end else if (burst_done) begin
          s_d.req = REQ_GAP;
        end
      end
      REQ_GAP: begin
        s_d.req = REQ_IDLE;
      end
      default: begin
        s_d.req = REQ_IDLE;
      end
    endcase

    // dma stops on count end; before then only a stop write clears running
    if (cnt_end) begin
      s_d.running = 1'b0;
    end

    // power transition timer
    if (s_q.pm == PM_MOVING) begin
      s_d.pm_timer = s_q.pm_timer - 4'(1);
      if (s_q.pm_timer == 4'(1)) begin
        s_d.pm_done = 1'b1;
        s_d.pm_cmd = 3'b000;
        s_d.pm = s_q.pm_cmd[2] ? PM_SLEEP :
          (s_q.pm_cmd[1] ? PM_ACTIVE : PM_CUT);
      end
    end

    // register read, valid the cycle after the strobe
    // sleep never blocks access: all shared registers stay open
    if (rd) begin
      unique case (addr)
        `ADR_TOP_STAT: s_d.rdata = top_val;
        `ADR_DEV_STAT: s_d.rdata = s_q.dev_st;
        `ADR_HOST_STAT: s_d.rdata = s_q.host_st;
        `ADR_CPU_STAT: s_d.rdata = s_q.cpu_st;
        `ADR_BUF_STAT: s_d.rdata = s_q.buf_st;
        `ADR_TOP_EN: s_d.rdata = s_q.top_en;
        `ADR_DEV_EN: s_d.rdata = s_q.dev_en;
        `ADR_HOST_EN: s_d.rdata = s_q.host_en;
        `ADR_CPU_EN: s_d.rdata = s_q.cpu_en;
        `ADR_BUF_EN: s_d.rdata = s_q.buf_en;
        `ADR_REVISION: s_d.rdata = `REVISION_VALUE; // arbitrary value
        `ADR_CHIP_RESET: s_d.rdata = s_q.chip_rst;
        `ADR_PM_CTRL: s_d.rdata = {s_q.pm_cmd, 3'b000, s_q.pm};
        `ADR_WAKE_HI: s_d.rdata = s_q.wake[15:8];
        `ADR_WAKE_LO: s_d.rdata = s_q.wake[7:0];
        `ADR_HOST_PWR: s_d.rdata = s_q.host_pwr;
        `ADR_HOST_XCVR: s_d.rdata = s_q.xcvr;
        `ADR_DEV_LINE: s_d.rdata = dev_line_in;
        `ADR_HOST_LINE: s_d.rdata = host_line_in;
        `ADR_XCVR_TUNE: s_d.rdata = s_q.tune;
        `ADR_ROLE_SEL: s_d.rdata = {7'h00, s_q.role};
        `ADR_DMA_CTRL: s_d.rdata = {s_q.running, 7'h00};
        `ADR_DMA_CFG: s_d.rdata = {4'h0, s_q.burst_cfg,
          s_q.free_run, s_q.count_mode};
        `ADR_DMA_CNT_HI: s_d.rdata = 8'(s_q.count >> 8);
        `ADR_DMA_CNT_LO: s_d.rdata = s_q.count[7:0];
        default: s_d.rdata = 8'h00;
      endcase
    end

    // register writes; write-one-to-clear comes before the sets below
    if (wr) begin
      wsel = 1'b1;
      unique case (addr)
        `ADR_TOP_STAT: begin
          if (wdata[`BIT_TOP_PM]) s_d.pm_done = 1'b0;
        end
        `ADR_DEV_STAT: s_d.dev_st = s_q.dev_st & ~wdata;
        `ADR_HOST_STAT: s_d.host_st = s_q.host_st & ~wdata;
        `ADR_CPU_STAT: s_d.cpu_st = s_q.cpu_st & ~wdata;
        `ADR_BUF_STAT: s_d.buf_st = s_q.buf_st & ~wdata;
        `ADR_TOP_EN: s_d.top_en = wdata;
        `ADR_DEV_EN: s_d.dev_en = wdata;
        `ADR_HOST_EN: s_d.host_en = wdata;
        `ADR_CPU_EN: s_d.cpu_en = wdata;
        `ADR_BUF_EN: s_d.buf_en = wdata;
        `ADR_CHIP_RESET: s_d.chip_rst = wdata;
        `ADR_PM_CTRL: begin
          if (s_q.pm != PM_MOVING && wdata[7:5] != 3'b000) begin
            s_d.pm_cmd = wdata[7:5];
            s_d.pm = PM_MOVING;
            s_d.pm_timer = 4'(`PM_CYCLES);
          end
        end
        `ADR_WAKE_HI: s_d.wake[15:8] = wdata;
        `ADR_WAKE_LO: s_d.wake[7:0] = wdata;
        `ADR_HOST_PWR: s_d.host_pwr = wdata;
        `ADR_HOST_XCVR: s_d.xcvr = wdata;
        `ADR_XCVR_TUNE: s_d.tune = wdata;
        `ADR_ROLE_SEL: s_d.role = wdata[0];
        `ADR_DMA_CTRL: begin
          if (wdata[`BIT_DMA_STOP]) begin
            s_d.running = 1'b0;
            s_d.req = REQ_IDLE;
          end else if (wdata[`BIT_DMA_GO]) begin
            s_d.running = 1'b1;
          end
        end
        `ADR_DMA_CFG: begin
          s_d.count_mode = wdata[`BIT_CFG_COUNT];
          s_d.free_run = wdata[`BIT_CFG_FREE];
          s_d.burst_cfg = wdata[3:2];
        end
        `ADR_DMA_CNT_HI: s_d.count = CNT_W'({wdata, s_q.count[7:0]});
        `ADR_DMA_CNT_LO: s_d.count[7:0] = wdata;
        default: wsel = 1'b0;
      endcase
    end

    // event sets win over a same-cycle clear
    s_d.dev_st = s_d.dev_st | dev_events;
    s_d.host_st = s_d.host_st | host_events;
    if (cnt_end) s_d.cpu_st[`BIT_CPU_DMA_DONE] = 1'b1;
    if (cnt_end) s_d.buf_st[`BIT_BUF_DMA_DONE] = 1'b1;
    if (cnt_wrap) s_d.cpu_st[`BIT_CPU_DMA_WRAP] = 1'b1;
    if (ram_read_complete) s_d.cpu_st[`BIT_CPU_RAM_RD] = 1'b1;
    if (empty_rise) s_d.buf_st[`BIT_BUF_EMPTY] = 1'b1;
    if (full_rise) s_d.buf_st[`BIT_BUF_FULL] = 1'b1;
    if (!buffer_empty) s_d.buf_st[`BIT_BUF_NEMPTY] = 1'b1;
    if (s_q.pm == PM_MOVING && s_q.pm_timer == 4'(1)) begin
      s_d.pm_done = 1'b1;
    end
    if (wsel && addr == `ADR_TOP_STAT) begin
      s_d.pm_done = s_d.pm_done;
    end
  end

  // ************************************************************
  // interrupt summary
  // ************************************************************
  // summary bits follow the enabled lower sources, no storage of their
  // own; kept as a signal so the interrupt pin follows every status
  // or enable change in the same cycle
  always_comb begin
    top_val = 8'h00;
    top_val[`BIT_TOP_DEV] = |(s_q.dev_st & s_q.dev_en);
    top_val[`BIT_TOP_HOST] = |(s_q.host_st & s_q.host_en);
    top_val[`BIT_TOP_CPU] = |(s_q.cpu_st & s_q.cpu_en);
    top_val[`BIT_TOP_BUF] = |(s_q.buf_st & s_q.buf_en);
    top_val[`BIT_TOP_PM] = s_q.pm_done;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.chip_rst <= `RST_CHIP_RESET;
      s_q.xcvr <= `RST_HOST_XCVR;
      s_q.pm <= PM_ACTIVE;
      s_q.ack_s <= 2'b11;
      s_q.prev_empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // data outputs straight from flops, no decode after the register
  assign rdata = s_q.rdata;
  // level interrupt; stays high until software clears or masks
  assign irq = |(top_val & s_q.top_en);
  // request low only while a burst is owed; gap and idle read high
  assign dma_request_n = !(s_q.req == REQ_ON);
  // control pins decoded from their register bits
  assign transceiver_reset = s_q.chip_rst[`BIT_XCVR_RESET];
  assign full_logic_reset = s_q.chip_rst[`BIT_FULL_RESET];
  assign role_host_select = s_q.role;
  assign power_state = s_q.pm;
endmodule : shared_regs_dma_burst_req

// *** verification/shared_regs_sva.sv ***
// assertions on the ports of the shared register bank
`timescale 1ns/1ns
module shared_regs_sva #(
  parameter int FILL_W = 13 // fill level width
) (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, low
  input wire logic [7:0] addr, // address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic irq, // interrupt
  input wire logic [FILL_W-1:0] buffer_fill, // readable bytes
  input wire logic buffer_readable, // open to reads
  input wire logic dma_strobe, // byte moved
  input wire logic dma_request_n, // request, low
  input wire logic transceiver_reset, // xcvr reset
  input wire logic role_host_select, // role
  input wire shared_regs_pkg::power_state_t power_state // state
);
  import shared_regs_pkg::*;
  // ****
  // helpers
  // ****
  logic [5:0] burst_q;
  // strobes while the request is low; 16 is the largest burst
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) burst_q <= '0;
    else if (dma_request_n) burst_q <= '0;
    else if (dma_strobe) burst_q <= burst_q + 6'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // properties
  // ****
  property p_req_cond;
    $fell(dma_request_n) |-> $past(buffer_readable) && $past(buffer_fill) > 1;
  endproperty
  a_req_cond: assert property (p_req_cond) else $error("no data");
  property p_gap;
    $rose(dma_request_n) |-> dma_request_n [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("request gap too short");
  property p_burst;
    !dma_request_n |-> burst_q <= 6'h10;
  endproperty
  a_burst: assert property (p_burst) else $error("burst overrun");
  property p_xcvr;
    wr && addr == 8'h11 |=> transceiver_reset == $past(wdata[7]);
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("xcvr reset bit");
  property p_role;
    wr && addr == 8'h1F |=> role_host_select == $past(wdata[0]);
  endproperty
  a_role: assert property (p_role) else $error("role bit");
  property p_pm_cmd;
    wr && addr == 8'h12 && |wdata[7:5] && power_state != PM_MOVING
      |=> power_state == PM_MOVING;
  endproperty
  a_pm_cmd: assert property (p_pm_cmd) else $error("pm command lost");
  property p_pm_walk;
    $rose(power_state == PM_MOVING) |->
      (power_state == PM_MOVING) [*8] ##1 power_state != PM_MOVING;
  endproperty
  a_pm_walk: assert property (p_pm_walk) else $error("pm move length");
  property p_irq_drop;
    wr && addr == 8'h08 && wdata == 8'h00 |=> !irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq unmasked");
  c_req: cover property ($fell(dma_request_n));
  c_sleep: cover property (power_state == PM_SLEEP);
  c_irq: cover property ($rose(irq));
endmodule : shared_regs_sva
bind shared_regs_dma_burst_req shared_regs_sva #(.FILL_W(FILL_W))
  shared_regs_sva_i (.*);

// *** verification/dma_master_model.sv ***
// external dma master answering the burst request
`timescale 1ns/1ns
module dma_master_model (
  input wire logic clk, // clock
  input wire logic slow, // wider gaps between bytes
  input wire logic dma_request_n, // request, low
  output logic dma_ack_n, // acknowledge, low
  output logic dma_strobe, // one byte moved
  output int moved // bytes moved so far
);
  // ****
  // transfer loop
  // ****
  // the request is looked at again only after the gap, so a
  // registered drop of the request is never run over
  initial begin
    dma_ack_n = 1'b1;
    dma_strobe = 1'b0;
    moved = 0;
    forever begin
      @(posedge clk);
      if (!dma_request_n) begin
        dma_ack_n <= 1'b0;
        repeat (3) @(posedge clk);
        while (!dma_request_n) begin
          dma_strobe <= 1'b1;
          moved <= moved + 1;
          @(posedge clk);
          dma_strobe <= 1'b0;
          repeat (slow ? 5 : 3) @(posedge clk);
        end
        dma_ack_n <= 1'b1;
      end
    end
  end
endmodule : dma_master_model

// *** verification/shared_regs_dma_burst_req_tb.sv ***
// self-checking bench for the shared register bank
`timescale 1ns/1ns
`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("CHECK FAILED at %0t: got %0h want %0h", $time, g, e); \
  end \
end
module shared_regs_dma_burst_req_tb;
  import shared_regs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, dev_events = 8'h00;
  logic [7:0] host_events = 8'h00, dev_line_in = 8'h00;
  logic [7:0] host_line_in = 8'h00, rdata, d;
  logic ram_read_complete = 1'b0, buffer_empty = 1'b1;
  logic buffer_full = 1'b0, buffer_readable = 1'b0, rd_seen = 1'b0;
  logic [12:0] buffer_fill = 13'h0000;
  logic irq, dma_ack_n, dma_strobe, dma_request_n, transceiver_reset;
  logic full_logic_reset, role_host_select;
  power_state_t power_state;
  logic [15:0] exp_q [$];
  logic [15:0] note;
  int fail_count = 0, checks = 0, seed = 65, moved, i;
  logic [15:0] rst_t [19] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300,
    16'h0800, 16'h0900, 16'h0A00, 16'h0B00, 16'h0C00, 16'h105A, 16'h1180,
    16'h1201, 16'h1400, 16'h1500, 16'h1600, 16'h1791, 16'h1B00, 16'h1F00,
    16'h0500};
  logic [15:0] rw_t [10] = '{16'h08F1, 16'h09BB, 16'h0ABB, 16'h0B83,
    16'h0C87, 16'h14FF, 16'h15FF, 16'h1680, 16'h17F3, 16'h1B33};
  logic [7:0] pm_c [3] = '{8'h20, 8'h40, 8'h80};
  power_state_t pm_s [3] = '{PM_CUT, PM_ACTIVE, PM_SLEEP};

  shared_regs_dma_burst_req shared_regs_dma_burst_req_i (.*);
  dma_master_model dma_master_model_i (.*);

  // 25 MHz
  always #20 clk = ~clk;

  // ****
  // bus tasks
  // ****
  // every strobe is set once per edge, so back-to-back is safe
  task automatic bus(input logic w, r, input logic [7:0] a, v);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= v;
    @(posedge clk);
  endtask : bus
  task automatic wr_reg(input logic [7:0] a, v);
    bus(1'b1, 1'b0, a, v);
  endtask : wr_reg
  task automatic idle();
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : idle
  // the note goes in before the strobe leaves
  task automatic rd_chk(input logic [7:0] a, m, e);
    exp_q.push_back({m, e});
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd_chk
  task automatic wait_moved(input int n);
    int k;
    for (k = 0; k < 300 && moved < n; k++) idle();
  endtask : wait_moved
  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // read data stand only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_seen) begin
      note = exp_q.pop_front();
      `CHK(rdata & note[15:8], note[7:0])
    end
    rd_seen = rd;
  end

  // a hang ends the run as a failure
  initial begin
    #800000;
    fail_count++;
    report_and_stop();
  end

  // ****
  // scenarios
  // ****
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 19; i++) begin
      rd_chk(rst_t[i][15:8], 8'hFF, rst_t[i][7:0]);
    end
    `CHK(transceiver_reset, 1'b1)
    `CHK(full_logic_reset, 1'b0)
    `CHK(role_host_select, 1'b0)
    // random values, reserved bits kept at zero
    for (i = 0; i < 10; i++) begin
      d = 8'($random(seed)) & rw_t[i][7:0];
      wr_reg(rw_t[i][15:8], d);
      rd_chk(rw_t[i][15:8], 8'hFF, d);
    end
    d = 8'($random(seed));
    dev_line_in <= d;
    host_line_in <= ~d;
    idle();
    rd_chk(8'h18, 8'hFF, d);
    rd_chk(8'h19, 8'hFF, ~d);
    // interrupt raised, masked and cleared
    wr_reg(8'h0B, 8'h80);
    wr_reg(8'h08, 8'h20);
    wr_reg(8'h09, 8'h00);
    ram_read_complete <= 1'b1;
    dev_events <= 8'h01;
    host_events <= 8'h80;
    idle();
    ram_read_complete <= 1'b0;
    dev_events <= 8'h00;
    host_events <= 8'h00;
    rd_chk(8'h03, 8'hFF, 8'h80);
    rd_chk(8'h00, 8'hA0, 8'h20);
    rd_chk(8'h01, 8'hFF, 8'h01);
    rd_chk(8'h02, 8'hFF, 8'h80);
    `CHK(irq, 1'b1)
    wr_reg(8'h08, 8'h00);
    idle();
    `CHK(irq, 1'b0)
    wr_reg(8'h09, 8'h01);
    rd_chk(8'h00, 8'h80, 8'h80);
    wr_reg(8'h01, 8'h01);
    wr_reg(8'h03, 8'h80);
    rd_chk(8'h00, 8'h80, 8'h00);
    rd_chk(8'h03, 8'hFF, 8'h00);
    // each power command; a second one during the move is refused
    for (i = 0; i < 3; i++) begin
      wr_reg(8'h12, pm_c[i]);
      wr_reg(8'h12, 8'h20);
      repeat (10) idle();
      `CHK(power_state, pm_s[i])
    end
    wr_reg(8'h1F, 8'h01);
    rd_chk(8'h1F, 8'hFF, 8'h01);
    `CHK(role_host_select, 1'b1)
    rd_chk(8'h00, 8'h01, 8'h01);
    wr_reg(8'h00, 8'h01);
    rd_chk(8'h00, 8'h01, 8'h00);
    wr_reg(8'h12, 8'h40);
    wr_reg(8'h11, 8'h01);
    idle();
    `CHK(transceiver_reset, 1'b0)
    `CHK(full_logic_reset, 1'b1)
    wr_reg(8'h11, 8'h80);
    repeat (10) idle();
    // count mode, 4-byte bursts, 6 bytes; fill equal to burst waits
    wr_reg(8'h41, 8'h05);
    wr_reg(8'h42, 8'h00);
    wr_reg(8'h43, 8'h06);
    buffer_readable <= 1'b1;
    buffer_fill <= 13'h0004;
    wr_reg(8'h40, 8'h01);
    rd_chk(8'h40, 8'h80, 8'h80);
    repeat (4) idle();
    `CHK(dma_request_n, 1'b1)
    buffer_fill <= 13'h0014;
    wait_moved(4);
    buffer_fill <= 13'h0003;
    wait_moved(6);
    repeat (12) idle();
    `CHK(moved, 6)
    `CHK(dma_request_n, 1'b1)
    rd_chk(8'h40, 8'h80, 8'h00);
    rd_chk(8'h03, 8'h01, 8'h01);
    rd_chk(8'h04, 8'h80, 8'h80);
    // free run past the counter end, 2-byte bursts, slow master, stop
    slow <= 1'b1;
    wr_reg(8'h41, 8'h02);
    wr_reg(8'h42, 8'hFF);
    wr_reg(8'h43, 8'hFE);
    buffer_fill <= 13'h0014;
    wr_reg(8'h40, 8'h01);
    wait_moved(16);
    buffer_fill <= 13'h0000;
    repeat (30) idle();
    `CHK(moved, 16)
    rd_chk(8'h03, 8'h02, 8'h02);
    rd_chk(8'h40, 8'h80, 8'h80);
    wr_reg(8'h40, 8'h02);
    idle();
    rd_chk(8'h40, 8'h80, 8'h00);
    // buffer level events: full and not-empty, then empty again
    buffer_empty <= 1'b0;
    buffer_full <= 1'b1;
    idle();
    buffer_empty <= 1'b1;
    buffer_full <= 1'b0;
    idle();
    rd_chk(8'h04, 8'h07, 8'h07);
    wr_reg(8'h04, 8'h07);
    rd_chk(8'h04, 8'h07, 8'h00);
    repeat (3) idle();
    report_and_stop();
  end
endmodule : shared_regs_dma_burst_req_tb
